// file: hw/psc_consts.svh
/*
 constant header for the power-up switch configuration decoder.
 assumes it is included by bare name by the decoder; the package needs none of it.
*/
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH
// ==========================================================
// serial parameter switch bank bit positions
`define PSC_SER_LEN_BIT 0
`define PSC_SER_PAR_HI 1
`define PSC_SER_PAR_LO 2
`define PSC_SER_STOP_BIT 3
`define PSC_SER_RATE_HI 4
`define PSC_SER_RATE_LO 5
`define PSC_SER_FLOW_HI 6
`define PSC_SER_FLOW_LO 7
// ==========================================================
// printer setup switch bank bit positions
`define PSC_SET_METHOD_BIT 0
`define PSC_SET_SENSOR_BIT 1
`define PSC_SET_HEADCHK_BIT 2
`define PSC_SET_HEXDUMP_BIT 3
`define PSC_SET_BUFFER_BIT 4
`define PSC_SET_FWLOAD_BIT 5
`define PSC_SET_CODESET_BIT 6
`define PSC_SET_LEGACY_BIT 7
// ==========================================================
// operation switch bank bit positions
`define PSC_OPR_MEDIA_HI 0
`define PSC_OPR_MEDIA_LO 1
`define PSC_OPR_NOSENSE_BIT 2
`define PSC_OPR_NOBACKFEED_BIT 3
`define PSC_OPR_NOEXT_BIT 4
`define PSC_OPR_TYPE_HI 5
`define PSC_OPR_TYPE_LO 6
`define PSC_OPR_REPRINT_BIT 7
// ==========================================================
// reset values and timing
`define PSC_BANK_RST 8'h00
`define PSC_SETTLE_NS 1000
`define PSC_CLK_NS 25
`define PSC_SETTLE_CYC ((`PSC_SETTLE_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`endif

// file: hw/psc_pkg.sv
/*
 types for the power-up switch configuration decoder.
 assumes it is compiled before the decoder and the bench; it needs no header.
*/
package psc_pkg;
   // ==========================================================
   // enumerated selections
   typedef enum logic [1:0] {PSC_PAR_NONE = 2'h0, PSC_PAR_EVEN = 2'h1,
      PSC_PAR_ODD = 2'h2} psc_parity_t;
   typedef enum logic [1:0] {PSC_BAUD_9600 = 2'h0, PSC_BAUD_19200 = 2'h1,
      PSC_BAUD_38400 = 2'h2, PSC_BAUD_57600 = 2'h3} psc_baud_t;
   typedef enum logic [2:0] {PSC_FLOW_RDYBSY = 3'h0, PSC_FLOW_XONXOFF = 3'h1,
      PSC_FLOW_STAT3 = 3'h2, PSC_FLOW_STAT4 = 3'h3, PSC_FLOW_LEGACY = 3'h4} psc_flow_t;
   typedef enum logic [1:0] {PSC_MEDIA_CONT = 2'h0, PSC_MEDIA_TEAR = 2'h1,
      PSC_MEDIA_CUT = 2'h2, PSC_MEDIA_DISP = 2'h3} psc_media_t;
   typedef enum logic [2:0] {PSC_TYPE_1 = 3'h1, PSC_TYPE_2 = 3'h2,
      PSC_TYPE_3 = 3'h3, PSC_TYPE_4 = 3'h4} psc_start_type_t;
   // ==========================================================
   // decoded serial framing
   typedef struct packed {
      logic seven_bits;
      psc_parity_t parity;
      logic two_stop;
      psc_baud_t baud;
      psc_flow_t flow;
   } psc_serial_t;
   // decoded printer setup
   typedef struct packed {
      logic direct_thermal;
      logic mark_sensor;
      logic head_check;
      logic hex_dump;
      logic multi_job;
      logic fw_download;
      logic alt_codes;
      logic legacy_cmds;
   } psc_setup_t;
   // decoded operation mode
   typedef struct packed {
      psc_media_t media;
      logic backfeed_after;
      logic auto_position;
      logic backfeed_en;
      logic ext_enable;
      psc_start_type_t start_type;
      logic reprint_en;
   } psc_oper_t;
endpackage : psc_pkg

// file: hw/psc_decoder.sv
/*
 power-up switch configuration decoder with head-open interlock.
 assumes the three switch banks are static mechanical inputs, the head switch
 and applicator signals are asynchronous pins, and SYS_RST_I marks power-up.
*/
`timescale 1ns/1ps
`include "psc_consts.svh"

// Overview of operation
// - switches sampled only at power-up
// - length bit selects eight or seven
// - parity field: none, even, odd, unused
// - stop bit selects one or two
// - rate field selects 9600 to 57600
// - flow field selects four protocols
// - legacy bit swaps variant four protocol
// - method bit: ribbon or direct thermal
// - sensor bit: gap or mark
// - head check bit enables element test
// - hex dump bit enables dump mode
// - buffer bit: single or multi job
// - update bit enables firmware load mode
// - code set bit: standard or alternate
// - media field and backfeed timing
// - sense bit: sensor or line feeds
// - backfeed bit enables backfeed offset
// - accept applicator start when enabled
// - external disable forces continuous, no backfeed
// - type field selects start form
// - reprint bit allows repeat requests
// - head open stops printing three clock edges after the pin
module psc_decoder (
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic [7:0] SERIAL_BANK_I,
   input wire logic [7:0] SETUP_BANK_I,
   input wire logic [7:0] OPER_BANK_I,
   input wire logic HEAD_OPEN_I,
   input wire logic APPL_START_I,
   input wire logic APPL_REPEAT_I,
   input wire logic PRINT_REQ_I,
   output psc_pkg::psc_serial_t SERIAL_CFG_O,
   output psc_pkg::psc_setup_t SETUP_CFG_O,
   output psc_pkg::psc_oper_t OPER_CFG_O,
   output logic CFG_VALID_O,
   output logic PRINT_EN_O,
   output logic START_LEVEL_O,
   output logic REPEAT_O
);
   import psc_pkg::*;

   // ==========================================================
   // power-up sequencer
   typedef enum logic [2:0] {PSC_ST_SETTLE = 3'b001, PSC_ST_LOAD = 3'b010,
      PSC_ST_RUN = 3'b100} psc_state_t;
   psc_state_t state; // sequencer state
   psc_state_t next_state; // next sequencer state
   logic [6:0] settle_cnt; // waits for synchronised banks to settle
   localparam logic [6:0] SETTLE_CYC = 7'(`PSC_SETTLE_CYC);

   // ==========================================================
   // synchronisers: banks and pins pass two flops
   logic [26:0] sync_a; // first stage, read only by sync_b
   logic [26:0] sync_b; // second stage
   // both stages run free with no reset; the settle wait flushes them
   // long before the banks are loaded, so no reset value is needed
   always_ff @(posedge REF_CLK_I) begin
      sync_a <= {PRINT_REQ_I, APPL_REPEAT_I, APPL_START_I, OPER_BANK_I,
         SETUP_BANK_I, SERIAL_BANK_I};
      sync_b <= sync_a;
   end
   logic [7:0] ser_s; // serial bank, synchronised
   logic [7:0] set_s; // setup bank, synchronised
   logic [7:0] opr_s; // operation bank, synchronised
   logic head_s; // head switch, synchronised
   logic start_s; // applicator start, synchronised
   logic repeat_s; // applicator repeat, synchronised
   logic req_s; // print request, synchronised
   logic head_a; // head first stage
   // the head switch has its own pair of flops, kept apart from the wide
   // bank vector so the interlock path stays easy to follow
   always_ff @(posedge REF_CLK_I) begin
      head_a <= HEAD_OPEN_I;
      head_s <= head_a;
   end
   assign ser_s = sync_b[7:0];
   assign set_s = sync_b[15:8];
   assign opr_s = sync_b[23:16];
   assign start_s = sync_b[24];
   assign repeat_s = sync_b[25];
   assign req_s = sync_b[26];

   // state register; reset is the power-up marker
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         state <= PSC_ST_SETTLE;
      end else begin
         state <= next_state;
      end
   end
   // settle counter runs only before the load
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         settle_cnt <= 7'h00;
      end else if (state == PSC_ST_SETTLE) begin
         settle_cnt <= settle_cnt + 7'h01;
      end
   end
   // run is terminal until reset, so later switch moves are ignored
   always_comb begin
      next_state = state;
      case (state)
         PSC_ST_SETTLE: begin
            if (settle_cnt >= SETTLE_CYC) begin
               next_state = PSC_ST_LOAD;
            end
         end
         PSC_ST_LOAD: begin
            next_state = PSC_ST_RUN;
         end
         PSC_ST_RUN: begin
            next_state = PSC_ST_RUN;
         end
         default: begin
            next_state = PSC_ST_SETTLE;
         end
      endcase
   end

   // ==========================================================
   // decode of the three banks
   psc_serial_t next_serial; // decoded serial framing
   psc_setup_t next_setup; // decoded setup
   psc_oper_t next_oper; // decoded operation
   always_comb begin
      next_serial.seven_bits = ser_s[`PSC_SER_LEN_BIT];
      next_serial.two_stop = ser_s[`PSC_SER_STOP_BIT];
      case ({ser_s[`PSC_SER_PAR_HI], ser_s[`PSC_SER_PAR_LO]})
         2'h1: begin
            next_serial.parity = PSC_PAR_EVEN;
         end
         2'h2: begin
            next_serial.parity = PSC_PAR_ODD;
         end
         default: begin
            next_serial.parity = PSC_PAR_NONE;
         end
      endcase
      next_serial.baud = psc_baud_t'({ser_s[`PSC_SER_RATE_HI],
         ser_s[`PSC_SER_RATE_LO]});
      case ({ser_s[`PSC_SER_FLOW_HI], ser_s[`PSC_SER_FLOW_LO]})
         2'h0: begin
            next_serial.flow = PSC_FLOW_RDYBSY;
         end
         2'h1: begin
            next_serial.flow = PSC_FLOW_XONXOFF;
         end
         2'h2: begin
            next_serial.flow = PSC_FLOW_STAT3;
         end
         default: begin
            // legacy emulation replaces variant four
            next_serial.flow = set_s[`PSC_SET_LEGACY_BIT] ? PSC_FLOW_LEGACY
               : PSC_FLOW_STAT4;
         end
      endcase
   end

   // setup bank: each switch lands in one field, on means set
   always_comb begin
      next_setup.direct_thermal = set_s[`PSC_SET_METHOD_BIT];
      next_setup.mark_sensor = set_s[`PSC_SET_SENSOR_BIT];
      next_setup.head_check = set_s[`PSC_SET_HEADCHK_BIT];
      next_setup.hex_dump = set_s[`PSC_SET_HEXDUMP_BIT];
      next_setup.multi_job = set_s[`PSC_SET_BUFFER_BIT];
      next_setup.fw_download = set_s[`PSC_SET_FWLOAD_BIT];
      next_setup.alt_codes = set_s[`PSC_SET_CODESET_BIT];
      next_setup.legacy_cmds = set_s[`PSC_SET_LEGACY_BIT];
   end

   // operation bank; the sense and backfeed switches act when off
   always_comb begin
      next_oper.auto_position = ~opr_s[`PSC_OPR_NOSENSE_BIT];
      next_oper.reprint_en = opr_s[`PSC_OPR_REPRINT_BIT];
      // media bit one also picks when backfeed runs
      next_oper.backfeed_after = opr_s[`PSC_OPR_MEDIA_HI];
      case ({opr_s[`PSC_OPR_TYPE_HI], opr_s[`PSC_OPR_TYPE_LO]})
         2'h0: begin
            next_oper.start_type = PSC_TYPE_4;
         end
         2'h1: begin
            next_oper.start_type = PSC_TYPE_3;
         end
         2'h2: begin
            next_oper.start_type = PSC_TYPE_2;
         end
         default: begin
            next_oper.start_type = PSC_TYPE_1;
         end
      endcase
      if (opr_s[`PSC_OPR_NOEXT_BIT]) begin
         // external disable overrides media and backfeed
         next_oper.media = PSC_MEDIA_CONT;
         next_oper.backfeed_en = 1'b0;
         next_oper.ext_enable = 1'b0;
      end else begin
         next_oper.media = psc_media_t'({opr_s[`PSC_OPR_MEDIA_HI],
            opr_s[`PSC_OPR_MEDIA_LO]});
         next_oper.backfeed_en = ~opr_s[`PSC_OPR_NOBACKFEED_BIT];
         next_oper.ext_enable = 1'b1;
      end
   end

   // ==========================================================
   // configuration registers, loaded once
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         SERIAL_CFG_O <= '0;
         SETUP_CFG_O <= '0;
         OPER_CFG_O <= '0;
         CFG_VALID_O <= 1'b0;
      end else if (state == PSC_ST_LOAD) begin
         SERIAL_CFG_O <= next_serial;
         SETUP_CFG_O <= next_setup;
         OPER_CFG_O <= next_oper;
         CFG_VALID_O <= 1'b1;
      end
   end

   // ==========================================================
   // print enable and applicator signals
   // head open clears the enable one edge after its synchroniser; three edges
   // from pin to enable is the price of a clean, glitch-free gate
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         PRINT_EN_O <= 1'b0;
      end else begin
         PRINT_EN_O <= CFG_VALID_O & req_s & ~head_s;
      end
   end
   // start level passes only while external signals are accepted
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         START_LEVEL_O <= 1'b0;
         REPEAT_O <= 1'b0;
      end else begin
         START_LEVEL_O <= CFG_VALID_O & OPER_CFG_O.ext_enable & start_s;
         REPEAT_O <= CFG_VALID_O & OPER_CFG_O.ext_enable & OPER_CFG_O.reprint_en
            & repeat_s;
      end
   end

   // ==========================================================
   // assertions
   // load checks compare stored fields (parity, start type and ext_enable for one value only, flow with legacy for code 3 only, legacy_cmds not at all)
   // with the synchronised bank one edge earlier, at the load edge itself; outside the load they are idle
   // and the hold checks take over
   a_cfg_held: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      CFG_VALID_O |=> $stable(SERIAL_CFG_O) && $stable(SETUP_CFG_O) && $stable(OPER_CFG_O))
      else $error("configuration changed after load");
   a_parity_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == PSC_ST_LOAD && ser_s[2:1] == 2'h3) |=> SERIAL_CFG_O.parity == PSC_PAR_NONE)
      else $error("unused parity not mapped to none");
   a_len_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> SERIAL_CFG_O.seven_bits == $past(ser_s[0]))
      else $error("length bit wrong");
   a_legacy_flow: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == PSC_ST_LOAD && ser_s[7:6] == 2'h3 && set_s[7])
      |=> SERIAL_CFG_O.flow == PSC_FLOW_LEGACY)
      else $error("legacy protocol not chosen");
   a_ext_override: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == PSC_ST_LOAD && opr_s[4]) |=> OPER_CFG_O.media == PSC_MEDIA_CONT
      && !OPER_CFG_O.backfeed_en && !OPER_CFG_O.ext_enable)
      else $error("external disable override missing");
   a_type_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == PSC_ST_LOAD && opr_s[6:5] == 2'h0) |=> OPER_CFG_O.start_type == PSC_TYPE_4)
      else $error("start type four wrong");
   a_head_stop: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      head_s |=> !PRINT_EN_O)
      else $error("printing with head open");
   a_start_gate: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      START_LEVEL_O |-> $past(OPER_CFG_O.ext_enable) && $past(start_s))
      else $error("start passed while disabled");
   a_repeat_gate: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      REPEAT_O |-> $past(OPER_CFG_O.reprint_en))
      else $error("repeat passed while disabled");
   a_load_time: assert property (@(posedge REF_CLK_I)
      $fell(SYS_RST_I) |-> ##[40:45] CFG_VALID_O)
      else $error("configuration not loaded in time");
   a_stop_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> SERIAL_CFG_O.two_stop == $past(ser_s[`PSC_SER_STOP_BIT]))
      else $error("stop length wrong");
   a_rate_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> SERIAL_CFG_O.baud == {$past(ser_s[`PSC_SER_RATE_HI]),
      $past(ser_s[`PSC_SER_RATE_LO])})
      else $error("bit rate wrong");
   a_flow_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == PSC_ST_LOAD && !set_s[`PSC_SET_LEGACY_BIT]) |=> SERIAL_CFG_O.flow
      == {1'b0, $past(ser_s[`PSC_SER_FLOW_HI]), $past(ser_s[`PSC_SER_FLOW_LO])})
      else $error("flow protocol wrong");
   a_method_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> SETUP_CFG_O.direct_thermal == $past(set_s[`PSC_SET_METHOD_BIT]))
      else $error("print method wrong");
   a_sensor_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> SETUP_CFG_O.mark_sensor == $past(set_s[`PSC_SET_SENSOR_BIT]))
      else $error("sensor type wrong");
   a_headchk_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> SETUP_CFG_O.head_check == $past(set_s[`PSC_SET_HEADCHK_BIT]))
      else $error("head check wrong");
   a_dump_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> SETUP_CFG_O.hex_dump == $past(set_s[`PSC_SET_HEXDUMP_BIT]))
      else $error("hex dump wrong");
   a_buffer_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> SETUP_CFG_O.multi_job == $past(set_s[`PSC_SET_BUFFER_BIT]))
      else $error("buffer policy wrong");
   a_fwload_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> SETUP_CFG_O.fw_download == $past(set_s[`PSC_SET_FWLOAD_BIT]))
      else $error("firmware load wrong");
   a_codes_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> SETUP_CFG_O.alt_codes == $past(set_s[`PSC_SET_CODESET_BIT]))
      else $error("code set wrong");
   a_media_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == PSC_ST_LOAD && !opr_s[`PSC_OPR_NOEXT_BIT]) |=> OPER_CFG_O.media
      == {$past(opr_s[`PSC_OPR_MEDIA_HI]), $past(opr_s[`PSC_OPR_MEDIA_LO])})
      else $error("media mode wrong");
   a_backfeed_when: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> OPER_CFG_O.backfeed_after == $past(opr_s[`PSC_OPR_MEDIA_HI]))
      else $error("backfeed timing wrong");
   a_sense_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> OPER_CFG_O.auto_position == !$past(opr_s[`PSC_OPR_NOSENSE_BIT]))
      else $error("label sensing wrong");
   a_backfeed_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == PSC_ST_LOAD && !opr_s[`PSC_OPR_NOEXT_BIT]) |=> OPER_CFG_O.backfeed_en
      == !$past(opr_s[`PSC_OPR_NOBACKFEED_BIT]))
      else $error("backfeed enable wrong");
   a_reprint_map: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      state == PSC_ST_LOAD |=> OPER_CFG_O.reprint_en == $past(opr_s[`PSC_OPR_REPRINT_BIT]))
      else $error("reprint enable wrong");
   a_valid_held: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      CFG_VALID_O |=> CFG_VALID_O)
      else $error("valid dropped before reset");
   // legacy protocol and variant four are the least likely codes to be reached by random banks
   c_legacy: cover property (@(posedge REF_CLK_I) SERIAL_CFG_O.flow == PSC_FLOW_LEGACY);
   c_load: cover property (@(posedge REF_CLK_I) $rose(CFG_VALID_O));
   c_print: cover property (@(posedge REF_CLK_I) PRINT_EN_O ##1 !PRINT_EN_O);
   c_start: cover property (@(posedge REF_CLK_I) START_LEVEL_O);
   c_repeat: cover property (@(posedge REF_CLK_I) REPEAT_O);
endmodule : psc_decoder

// file: tb/psc_field_model.sv
/*
 model of the parts facing the decoder: three switch banks and an applicator.
 assumes the bench drives the wanted switch and applicator states shortly after
 a rising clock edge.
*/
`timescale 1ns/1ps
module psc_field_model (
   input wire logic clk_i,
   input wire logic [7:0] serial_want_i,
   input wire logic [7:0] setup_want_i,
   input wire logic [7:0] oper_want_i,
   input wire logic start_want_i,
   input wire logic repeat_want_i,
   output logic [7:0] serial_bank_o,
   output logic [7:0] setup_bank_o,
   output logic [7:0] oper_bank_o,
   output logic appl_start_o,
   output logic appl_repeat_o
);
   // ==========================================================
   // switch contacts
   logic [23:0] last = 24'h000000; // settled position of all contacts
   logic bounce = 1'b0; // high for one cycle after a flip
   // a flipped switch chatters: the banks show the inverse for one cycle,
   // so a decoder that samples outside power-up sees garbage, not the target
   always_ff @(posedge clk_i) begin
      bounce <= ({serial_want_i, setup_want_i, oper_want_i} != last);
      last <= {serial_want_i, setup_want_i, oper_want_i};
   end
   assign serial_bank_o = bounce ? ~serial_want_i : serial_want_i;
   assign setup_bank_o = bounce ? ~setup_want_i : setup_want_i;
   assign oper_bank_o = bounce ? ~oper_want_i : oper_want_i;
   // ==========================================================
   // applicator
   assign appl_start_o = start_want_i;
   assign appl_repeat_o = repeat_want_i;
endmodule : psc_field_model

// file: tb/powerup_switch_config_decoder_tb.sv
/*
 self-checking bench for the power-up switch configuration decoder.
 assumes the package, the decoder and the field model are compiled first.
*/
`timescale 1ns/1ps
module powerup_switch_config_decoder_tb;
   import psc_pkg::*;
   // ==========================================================
   // stimulus and wiring
   logic clk = 1'b0; // 40 mhz reference
   logic rst = 1'b1; // power-up marker
   logic [7:0] want_s = 8'h00; // wanted serial bank
   logic [7:0] want_p = 8'h00; // wanted setup bank
   logic [7:0] want_o = 8'h00; // wanted operation bank
   logic head = 1'b0; // head open switch
   logic req = 1'b0; // print request
   logic start = 1'b0; // applicator start wanted
   logic rep = 1'b0; // applicator repeat wanted
   logic [7:0] s, p, o; // banks of the current power-up
   logic [1:0] c; // field code for directed power-ups
   wire logic [7:0] bank_s, bank_p, bank_o;
   wire logic appl_start, appl_rep;
   psc_serial_t ser_cfg;
   psc_setup_t set_cfg;
   psc_oper_t opr_cfg;
   logic cfg_valid, print_en, start_lvl, repeat_out;
   int err_count = 0;
   int n_tests = 0;
   initial begin
      forever #12.5 clk = ~clk;
   end
   psc_field_model field (.clk_i(clk), .serial_want_i(want_s), .setup_want_i(want_p),
      .oper_want_i(want_o), .start_want_i(start), .repeat_want_i(rep),
      .serial_bank_o(bank_s), .setup_bank_o(bank_p), .oper_bank_o(bank_o),
      .appl_start_o(appl_start), .appl_repeat_o(appl_rep));
   psc_decoder dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .SERIAL_BANK_I(bank_s),
      .SETUP_BANK_I(bank_p), .OPER_BANK_I(bank_o), .HEAD_OPEN_I(head),
      .APPL_START_I(appl_start), .APPL_REPEAT_I(appl_rep), .PRINT_REQ_I(req),
      .SERIAL_CFG_O(ser_cfg), .SETUP_CFG_O(set_cfg), .OPER_CFG_O(opr_cfg),
      .CFG_VALID_O(cfg_valid), .PRINT_EN_O(print_en), .START_LEVEL_O(start_lvl),
      .REPEAT_O(repeat_out));
   // ==========================================================
   // reference model
   function automatic psc_serial_t exp_serial(input logic [7:0] b, input logic leg);
      psc_serial_t r;
      int par, flow;
      par = b[1] * 2 + b[2];
      flow = b[6] * 2 + b[7];
      if (par == 3) par = 0; // unused code reads as none
      if (flow == 3 && leg) flow = 4; // legacy protocol replaces variant four
      r.seven_bits = b[0];
      r.parity = psc_parity_t'(par);
      r.two_stop = b[3];
      r.baud = psc_baud_t'(b[4] * 2 + b[5]);
      r.flow = psc_flow_t'(flow);
      return r;
   endfunction : exp_serial
   function automatic psc_setup_t exp_setup(input logic [7:0] b);
      logic [7:0] r;
      // switch one lands in the first struct field, which is the msb
      for (int i = 0; i < 8; i++) r[7 - i] = b[i];
      return psc_setup_t'(r);
   endfunction : exp_setup
   function automatic psc_oper_t exp_oper(input logic [7:0] b);
      psc_oper_t r;
      r.media = b[4] ? PSC_MEDIA_CONT : psc_media_t'(b[0] * 2 + b[1]);
      r.backfeed_after = b[0];
      r.auto_position = ~b[2];
      r.backfeed_en = ~b[3] & ~b[4];
      r.ext_enable = ~b[4];
      r.start_type = psc_start_type_t'(4 - (b[5] * 2 + b[6]));
      r.reprint_en = b[7];
      return r;
   endfunction : exp_oper
   // ==========================================================
   // helpers
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #2;
      end
   endtask : tick
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   // one power cycle: load banks, compare, flip switches, then exercise the pins
   task automatic power_up();
      int w;
      want_s = s;
      want_p = p;
      want_o = o;
      rst = 1'b1;
      {head, req, start, rep} = 4'h7; // requests pending but not yet allowed
      tick(12);
      check("outputs in reset", {cfg_valid, print_en, start_lvl, repeat_out}, 0);
      rst = 1'b0;
      w = 0;
      while (cfg_valid !== 1'b1) begin
         w++;
         if (w > 200) begin
            err_count++;
            $display("mismatch cfg_valid expected 1 seen timeout");
            tally_and_finish();
         end
         check("gated before load", {print_en, start_lvl, repeat_out}, 0);
         tick(1);
      end
      check("settle wait", w >= 40, 1);
      check("serial cfg", ser_cfg, exp_serial(s, p[7]));
      check("setup cfg", set_cfg, exp_setup(p));
      check("oper cfg", opr_cfg, exp_oper(o));
      want_s = ~s;
      want_p = ~p;
      want_o = ~o;
      tick(8);
      check("serial held", ser_cfg, exp_serial(s, p[7]));
      check("setup held", set_cfg, exp_setup(p));
      check("oper held", opr_cfg, exp_oper(o));
      for (int j = 0; j < 16; j++) begin
         {rep, start, req, head} = j[3:0];
         tick(4);
         check("print en", print_en, req & ~head);
         check("start level", start_lvl, start & ~o[4]);
         check("repeat", repeat_out, rep & ~o[4] & o[7]);
      end
   endtask : power_up
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(83));
      for (int k = 0; k < 16; k++) begin
         s = 8'($urandom);
         p = 8'($urandom);
         o = 8'($urandom);
         // first eight power-ups set every two-bit field to each code,
         // once with legacy mode off and external signals on, once with legacy on and external signals off
         if (k < 8) begin
            c = k[1:0];
            {s[1], s[2], s[4], s[5], s[6], s[7]} = {c, c, c};
            {o[0], o[1], o[5], o[6]} = {c, c};
            p[7] = k[2];
            o[4] = k[2];
         end
         power_up();
      end
      tally_and_finish();
   end
endmodule : powerup_switch_config_decoder_tb
